// ### include/odr_cfg.svh
/*
 Constants for the orientation detector and range configuration block.
 Assumes inclusion by bare name from design files.
*/
`ifndef ODR_CFG_SVH
`define ODR_CFG_SVH
`define ODR_OFS_RANGE      8'h0e
`define ODR_OFS_STATUS     8'h10
`define ODR_OFS_CONFIG     8'h11
`define ODR_OFS_COUNT      8'h12
`define ODR_OFS_ZCOMP      8'h13
`define ODR_OFS_THS        8'h14
`define ODR_ZCOMP_VAL      8'h44
`define ODR_THS_VAL        8'h84
`define ODR_CFG_MODE_BIT   7
`define ODR_CFG_EN_BIT     6
`define ODR_ST_FLAG_BIT    7
`define ODR_ST_LOCK_BIT    6
`define ODR_ST_CODE_HI     2
`define ODR_ST_CODE_LO     1
`define ODR_ST_FACE_BIT    0
`define ODR_FS_2G          2'h0
`define ODR_FS_4G          2'h1
`define ODR_FS_8G          2'h2
`define ODR_LIMIT_MG       16'd1250
`define ODR_LOCK_MG        16'd866
`define ODR_BACK_MG        16'sd259
`define ODR_STEP_NORM_US   32'd20000
`define ODR_STEP_LNLP_US   32'd80000
`define ODR_STEP_LP_US     32'd160000
`define ODR_STEP_HR_US     32'd2500
`define ODR_CLK_MHZ        32'd100
`endif

// ### include/odr_pkg.sv
/*
 Types for the orientation detector block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package odr_pkg;
  typedef enum logic [3:0] {
    ODR_OS_NORMAL = 4'h1,
    ODR_OS_LNLP   = 4'h2,
    ODR_OS_HIRES  = 4'h4,
    ODR_OS_LOWPWR = 4'h8
  } odr_os_t;

  typedef struct packed {
    logic       lockout;
    logic [1:0] code;
    logic       face;
  } odr_orient_t;

  typedef struct packed {
    logic signed [15:0] x_mg;
    logic signed [15:0] y_mg;
    logic signed [15:0] z_mg;
  } odr_accel_t;
endpackage : odr_pkg

// ### core/odr_step_timer.sv
/*
 Debounce time-step generator: one pulse per step, step = min(1/rate, mode cap).
 Assumes the sample period in microseconds is supplied by the rate logic elsewhere.
*/
`timescale 1ns/1ps
`default_nettype none
`include "odr_cfg.svh"
module odr_step_timer #(
  parameter int CLK_MHZ = 100
) (
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic           clk_en,
  input  wire logic           restart,
  input  wire logic [31:0]    sample_period_us,
  input  wire odr_pkg::odr_os_t os_mode,
  output logic                step_pulse
);
  logic [31:0] cap_us;
  logic [31:0] step_us;
  logic [31:0] step_cyc;
  logic [31:0] cnt_q;

  always_comb begin
    unique case (os_mode)
      odr_pkg::ODR_OS_NORMAL: cap_us = `ODR_STEP_NORM_US;
      odr_pkg::ODR_OS_LNLP:   cap_us = `ODR_STEP_LNLP_US;
      odr_pkg::ODR_OS_HIRES:  cap_us = `ODR_STEP_HR_US;
      odr_pkg::ODR_OS_LOWPWR: cap_us = `ODR_STEP_LP_US;
      default:                cap_us = `ODR_STEP_NORM_US;
    endcase
    step_us  = (sample_period_us < cap_us) ? sample_period_us : cap_us;
    step_cyc = (step_us == 32'h0) ? 32'h1 : step_us * 32'(CLK_MHZ);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q      <= 32'h0;
      step_pulse <= 1'b0;
    end else if (clk_en) begin
      if (restart || cnt_q + 32'h1 >= step_cyc) begin
        cnt_q      <= 32'h0;
        step_pulse <= !restart;
      end else begin
        cnt_q      <= cnt_q + 32'h1;
        step_pulse <= 1'b0;
      end
    end
  end
endmodule : odr_step_timer
`default_nettype wire

// ### core/odr_classifier.sv
/*
 Orientation classifier: candidate orientation and overload guard from one sample.
 Assumes signed milli-g inputs; fixed trip angles as coded below.
*/
`timescale 1ns/1ps
`default_nettype none
`include "odr_cfg.svh"
module odr_classifier (
  input  wire odr_pkg::odr_accel_t accel,
  output odr_pkg::odr_orient_t     cand,
  output logic                     overload
);
  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction

  logic [15:0] ax;
  logic [15:0] ay;
  logic [15:0] az;
  always_comb begin
    ax = mag(accel.x_mg);
    ay = mag(accel.y_mg);
    az = mag(accel.z_mg);
    // Any axis beyond the limit freezes transitions
    overload = (ax > `ODR_LIMIT_MG) || (ay > `ODR_LIMIT_MG) || (az > `ODR_LIMIT_MG);
    // Lockout near flat: |z| above cos(30 deg) of 1 g, roughly 866 mg
    cand.lockout = az > `ODR_LOCK_MG;
    // Back facing beyond 75 deg: z below -sin(15 deg), roughly -259 mg
    cand.face = accel.z_mg < -`ODR_BACK_MG;
    if (ay >= ax) begin
      cand.code = accel.y_mg[15] ? 2'h1 : 2'h0;
    end else begin
      cand.code = accel.x_mg[15] ? 2'h3 : 2'h2;
    end
  end
endmodule : odr_classifier
`default_nettype wire

// ### core/odr_orient_top.sv
/*
 Orientation detector with range configuration register set.
 Assumes a byte register port decoded from the serial host link elsewhere,
 sample strobes with acceleration in milli-g, and system mode inputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "odr_cfg.svh"
module odr_orient_top (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                clk_en,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                active,
  input  wire logic                sleep,
  input  wire logic [31:0]         sample_period_us,
  input  wire odr_pkg::odr_os_t    os_mode,
  input  wire logic                sample_valid,
  input  wire odr_pkg::odr_accel_t accel,
  input  wire logic                orient_irq_en,
  output logic [7:0]               reg_rdata,
  output logic [1:0]               full_scale_sel,
  output logic                     orient_irq_source
);
  logic [1:0]           range_q;
  logic                 debounce_mode_sel_q;
  logic                 orient_detect_en_q;
  logic [7:0]           debounce_count_value_q;
  odr_pkg::odr_orient_t orient_q;
  odr_pkg::odr_orient_t cand_q;
  odr_pkg::odr_orient_t cand;
  logic                 orient_change_flag_q;
  logic                 first_pending_q;
  logic [7:0]           dbc_q;
  logic                 sleep_q;
  logic                 overload;
  logic                 step_pulse;
  logic                 status_rd;
  logic                 commit;
  logic [7:0]           status_byte;
  logic                 step_restart;

  assign status_rd = reg_rd && (reg_addr == `ODR_OFS_STATUS);
  assign status_byte = {orient_change_flag_q, orient_q.lockout, 3'h0,
                        orient_q.code, orient_q.face};

  odr_classifier u_cls (
    .accel    (accel),
    .cand     (cand),
    .overload (overload)
  );

  // Timer restarts with each new candidate so a full step elapses before the first count
  assign step_restart = (sleep != sleep_q) ||
                        (sample_valid && !overload && cand != cand_q);

  odr_step_timer #(.CLK_MHZ(100)) u_step (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .clk_en           (clk_en),
    .restart          (step_restart),
    .sample_period_us (sample_period_us),
    .os_mode          (os_mode),
    .step_pulse       (step_pulse)
  );

  // Configuration registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      range_q                <= `ODR_FS_2G;
      debounce_mode_sel_q    <= 1'b0;
      orient_detect_en_q     <= 1'b0;
      debounce_count_value_q <= 8'h00;
    end else if (clk_en && reg_wr) begin
      unique case (reg_addr)
        `ODR_OFS_RANGE:  range_q <= reg_wdata[1:0];
        `ODR_OFS_CONFIG: begin
          debounce_mode_sel_q <= reg_wdata[`ODR_CFG_MODE_BIT];
          orient_detect_en_q  <= reg_wdata[`ODR_CFG_EN_BIT];
        end
        `ODR_OFS_COUNT:  debounce_count_value_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Reserved code reads back but decodes as 2 g downstream
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      full_scale_sel <= `ODR_FS_2G;
    end else if (clk_en) begin
      full_scale_sel <= (range_q == 2'h3) ? `ODR_FS_2G : range_q;
    end
  end

  // Debounce: counter runs in time steps while the candidate differs
  assign commit = sample_valid && !overload && orient_detect_en_q &&
                  (cand != orient_q || first_pending_q) &&
                  (debounce_count_value_q == 8'h00 ||
                   (cand == cand_q && dbc_q >= debounce_count_value_q));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dbc_q   <= 8'h00;
      cand_q  <= '0;
      sleep_q <= 1'b0;
    end else if (clk_en) begin
      sleep_q <= sleep;
      if (sleep != sleep_q || !active || !orient_detect_en_q) begin
        dbc_q <= 8'h00;
      end else if (sample_valid && !overload) begin
        cand_q <= cand;
        if (commit) begin
          dbc_q <= 8'h00;
        end else if (cand == orient_q && !first_pending_q) begin
          if (debounce_mode_sel_q) begin
            dbc_q <= (dbc_q == 8'h00) ? 8'h00 : dbc_q - 8'h01;
          end else begin
            dbc_q <= 8'h00;
          end
        end else if (cand != cand_q) begin
          dbc_q <= 8'h00;
        end else if (step_pulse && dbc_q != 8'hff) begin
          // A step landing on a sample cycle still counts
          dbc_q <= dbc_q + 8'h01;
        end
      end else if (step_pulse && cand_q != orient_q && dbc_q != 8'hff) begin
        dbc_q <= dbc_q + 8'h01;
      end
    end
  end

  // Orientation state, updated even while the flag stands
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      orient_q <= '0;
    end else if (clk_en && commit) begin
      orient_q <= cand;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_pending_q <= 1'b1;
    end else if (clk_en) begin
      if (!active) begin
        first_pending_q <= 1'b1;
      end else if (commit) begin
        first_pending_q <= 1'b0;
      end
    end
  end

  // Set wins over the clearing read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      orient_change_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (commit) begin
        orient_change_flag_q <= 1'b1;
      end else if (status_rd) begin
        orient_change_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      orient_irq_source <= 1'b0;
    end else if (clk_en) begin
      if (commit && orient_irq_en) begin
        orient_irq_source <= 1'b1;
      end else if (status_rd) begin
        orient_irq_source <= 1'b0;
      end
    end
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      unique case (reg_addr)
        `ODR_OFS_RANGE:  reg_rdata <= {6'h0, range_q};
        `ODR_OFS_STATUS: reg_rdata <= status_byte;
        `ODR_OFS_CONFIG: reg_rdata <= {debounce_mode_sel_q, orient_detect_en_q, 6'h0};
        `ODR_OFS_COUNT:  reg_rdata <= debounce_count_value_q;
        `ODR_OFS_ZCOMP:  reg_rdata <= `ODR_ZCOMP_VAL;
        `ODR_OFS_THS:    reg_rdata <= `ODR_THS_VAL;
        default:         reg_rdata <= 8'h00;
      endcase
    end
  end

  flag_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && status_rd && !commit |=> !orient_change_flag_q)
    else $error("change flag not cleared by status read");
  flag_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && commit |=> orient_change_flag_q)
    else $error("change flag not set on commit");
  freeze_ovl_a: assert property (@(posedge clk) disable iff (sys_rst)
    sample_valid && overload |-> !commit)
    else $error("commit during overload");
  disabled_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !orient_detect_en_q |=> $stable(orient_q))
    else $error("orientation moved while disabled");
  irq_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && commit && orient_irq_en |=> orient_irq_source)
    else $error("irq source not set");
  sleep_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && (sleep != sleep_q) |=> dbc_q == 8'h00)
    else $error("debounce not reset on wake/sleep change");
  zcomp_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && reg_rd && reg_addr == `ODR_OFS_ZCOMP |=> reg_rdata == 8'h44)
    else $error("lockout constant wrong");
  ths_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && reg_rd && reg_addr == `ODR_OFS_THS |=> reg_rdata == 8'h84)
    else $error("threshold constant wrong");
  range_map_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && range_q != 2'h3 |=> full_scale_sel == $past(range_q))
    else $error("range select mismatch");

  commit_c: cover property (@(posedge clk) disable iff (sys_rst) commit);
  clear_c: cover property (@(posedge clk) disable iff (sys_rst)
    orient_change_flag_q && status_rd);
  ovl_c: cover property (@(posedge clk) disable iff (sys_rst) sample_valid && overload);
endmodule : odr_orient_top
`default_nettype wire

// ### test/odr_host_model.sv
/*
 Host model: byte reads and writes on the block's register port.
 Assumes the port is taken at a rising edge and read data is settled a cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module odr_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic            wr,
  output logic            rd,
  output logic [7:0]      addr,
  output logic [7:0]      wdata
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end

  // Released lines show the inverse, so stale values are never mistaken for live ones
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    #1;
    d = rdata;
  endtask : read_reg
endmodule : odr_host_model
`default_nettype wire

// ### test/orientation_detect_range_cfg_tb_top.sv
/*
 Testbench: register access and orientation scenarios through the host model.
 Assumes the design files and package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module orientation_detect_range_cfg_tb_top;
  logic                clk;
  logic                sys_rst;
  logic                active;
  logic                clk_en;
  logic                sleep;
  logic                sample_valid;
  logic                orient_irq_en;
  logic                reg_wr;
  logic                reg_rd;
  logic [7:0]          reg_addr;
  logic [7:0]          reg_wdata;
  logic [7:0]          reg_rdata;
  logic [7:0]          rd_v;
  logic [1:0]          full_scale_sel;
  logic                orient_irq_source;
  logic [31:0]         sample_period_us;
  odr_pkg::odr_accel_t accel;
  int                  n_fail;
  int                  comparisons;
  time                 t0;
  logic [7:0]          ofs [7] = '{8'h0e, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};
  logic [7:0]          rstv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h44, 8'h84, 8'h00};

  always #5 clk = ~clk;

  odr_host_model host (
    .clk   (clk),
    .rdata (reg_rdata),
    .wr    (reg_wr),
    .rd    (reg_rd),
    .addr  (reg_addr),
    .wdata (reg_wdata)
  );

  // Oversampling stays fixed: a 1 us period keeps debounce steps short
  odr_orient_top uut (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .clk_en            (clk_en),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .active            (active),
    .sleep             (sleep),
    .sample_period_us  (sample_period_us),
    .os_mode           (odr_pkg::ODR_OS_NORMAL),
    .sample_valid      (sample_valid),
    .accel             (accel),
    .orient_irq_en     (orient_irq_en),
    .reg_rdata         (reg_rdata),
    .full_scale_sel    (full_scale_sel),
    .orient_irq_source (orient_irq_source)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
    host.read_reg(a, rd_v);
    check(rd_v, exp);
  endtask : expect_reg

  task automatic push(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    @(posedge clk);
    sample_valid <= 1'b1;
    accel <= {x, y, z};
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : push

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    active = 1'b0;
    clk_en = 1'b1;
    sleep = 1'b0;
    sample_valid = 1'b0;
    orient_irq_en = 1'b1;
    sample_period_us = 32'h1;
    accel = '0;
    n_fail = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    active <= 1'b1;
    for (int i = 0; i < 7; i++) expect_reg(ofs[i], rstv[i]);
    for (int i = 0; i < 4; i++) begin
      host.write_reg(8'h0e, 8'(i));
      expect_reg(8'h0e, 8'(i));
      check({6'h00, full_scale_sel}, (i == 3) ? 8'h00 : 8'(i));
    end
    host.write_reg(8'h0e, 8'h00);
    // Disabled clock enable must freeze the register file
    clk_en <= 1'b0;
    host.write_reg(8'h0e, 8'h02);
    clk_en <= 1'b1;
    expect_reg(8'h0e, 8'h00);
    host.write_reg(8'h13, 8'hff);
    host.write_reg(8'h14, 8'h00);
    host.write_reg(8'h10, 8'hff);
    expect_reg(8'h13, 8'h44);
    expect_reg(8'h14, 8'h84);
    host.write_reg(8'h11, 8'hc0);
    expect_reg(8'h11, 8'hc0);
    host.write_reg(8'h11, 8'h00);
    push(16'h0000, -16'sd1000, 16'h0000);
    expect_reg(8'h10, 8'h00);
    host.write_reg(8'h11, 8'h40);
    // First detection flags even though it matches the reset orientation
    push(16'h0000, 16'd500, 16'h0000);
    check({7'h00, orient_irq_source}, 8'h01);
    expect_reg(8'h10, 8'h80);
    expect_reg(8'h10, 8'h00);
    check({7'h00, orient_irq_source}, 8'h00);
    push(16'h0000, -16'sd1000, 16'h0000);
    push(16'd1000, 16'h0000, 16'h0000);
    expect_reg(8'h10, 8'h84);
    push(16'd1300, -16'sd1000, 16'h0000);
    expect_reg(8'h10, 8'h04);
    orient_irq_en <= 1'b0;
    push(-16'sd1000, 16'h0000, 16'h0000);
    check({7'h00, orient_irq_source}, 8'h00);
    expect_reg(8'h10, 8'h86);
    orient_irq_en <= 1'b1;
    push(16'h0000, 16'h0000, -16'sd1000);
    expect_reg(8'h10, 8'hc1);
    host.write_reg(8'h12, 8'h03);
    expect_reg(8'h12, 8'h03);
    t0 = $time;
    push(16'h0000, -16'sd1000, 16'h0000);
    expect_reg(8'h10, 8'h41);
    // Wake to sleep restarts the debounce from zero
    t0 = $time;
    sleep <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      push(16'h0000, -16'sd1000, 16'h0000);
      host.read_reg(8'h10, rd_v);
      if (rd_v[7]) begin
        break;
      end
    end
    // A timed-out loop leaves the flag clear and fails here
    check(rd_v, 8'h82);
    check({7'h00, ($time - t0) >= 3000}, 8'h01);
    final_report();
  end
endmodule : orientation_detect_range_cfg_tb_top
`default_nettype wire
